// [design/tcg_pkg.sv]
// Notes on behaviour
// - Direction bit 1 makes a dedicated pin a driven output, 0 a floating input.
// - Dedicated input pins are sampled once per fixed 16 ms cycle only.
// - The eight drive lines are always outputs, with no direction control.
// - Pin direction register reads 0 after reset: all dedicated pins are inputs.
// - PWM enable bit 1 toggles the pin at the shared duty level; reset 0.
// - PWM reaches a dedicated pin only while its direction bit is output.
// - Drive lines show their output level only outside measurement bursts.
// - PWM transitions are frozen during a measurement and resume between them.
// - Duty level 0-10 gives always on, 250-255 always off; reset 0.
// - Wake-enabled input pins are still sampled while sensing is asleep.
// - A wake-enabled input change in sleep raises the change notification.
// - Two consecutive bytes form the 16-bit key mask, key 0 at bit 0.
// - An empty common-change key mask forces the common-change flag to 1.
// - Key signals read as two bytes per key, low byte first, key order.
// - Key references read as two bytes per key, low byte first, key order.
// - The signal and reference area is read-only; writes change nothing.
// - Host reaches all setups over two-wire bus, single or block accesses.
// - Low-power value 0 means sleep; 1-255 sets interval in 16 ms; reset 1.
// - Output pins follow their drive-level bit, high for 1; reset 0.
// - An enabled PWM waveform overrides the pin's static drive-level bit.
package tcg_pkg;
   localparam logic [7:0] ADDR_LOW_POWER = 8'h0c;
   localparam logic [7:0] ADDR_DRIVE_LINES = 8'h46;
   localparam logic [7:0] ADDR_DRIVE_PINS = 8'h47;
   localparam logic [7:0] ADDR_PIN_LEVEL = 8'h48;
   localparam logic [7:0] ADDR_PIN_DIR = 8'h49;
   localparam logic [7:0] ADDR_LINE_PWM = 8'h4a;
   localparam logic [7:0] ADDR_PIN_PWM = 8'h4b;
   localparam logic [7:0] ADDR_PWM_LEVEL = 8'h4c;
   localparam logic [7:0] ADDR_WAKE = 8'h4d;
   localparam logic [7:0] ADDR_CC_MASK_LO = 8'h4e;
   localparam logic [7:0] ADDR_CC_MASK_HI = 8'h4f;
   localparam logic [7:0] ADDR_SIGNAL_FIRST = 8'h64;
   localparam logic [7:0] ADDR_SIGNAL_LAST = 8'h83;
   localparam logic [7:0] ADDR_REF_FIRST = 8'h84;
   localparam logic [7:0] ADDR_REF_LAST = 8'ha3;
   // Dedicated pins sit in bits 4:2 of their bytes
   localparam int PIN_LSB = 2;
   localparam logic [7:0] PIN_BITS = 8'h1c;
   localparam logic [7:0] RST_LOW_POWER = 8'h01;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] DUTY_FULL_ON_MAX = 8'h0a;
   localparam logic [7:0] DUTY_FULL_OFF_MIN = 8'hfa;
   // Slave address is arbitrary
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a;
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned INPUT_SAMPLE_MS = 16;
   localparam int unsigned INPUT_SAMPLE_CYCLES =
      INPUT_SAMPLE_MS * 1000000 / CLK_PERIOD_NS;
   localparam logic [3:0] BYTE_BITS = 4'h8;

   typedef struct packed {
      logic [15:0] signal;
      logic [15:0] reference;
   } tcg_key_s;

   typedef struct packed {
      logic [2:0] level;
      logic [2:0] enable;
   } tcg_pin_drv_s;

   typedef enum logic [8:0] {
      BUS_IDLE = 9'h001,
      BUS_DEV = 9'h002,
      BUS_DEV_ACK = 9'h004,
      BUS_PTR = 9'h008,
      BUS_PTR_ACK = 9'h010,
      BUS_WR = 9'h020,
      BUS_WR_ACK = 9'h040,
      BUS_RD = 9'h080,
      BUS_RD_ACK = 9'h100
   } tcg_bus_e;
endpackage

// [design/tcg_gpio_pwm_wake.sv]
`timescale 1ns/10ps
module tcg_gpio_pwm_wake
   import tcg_pkg::*;
#(
   parameter int unsigned SAMPLE_CYCLES = INPUT_SAMPLE_CYCLES,
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // Two-wire slave pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   // Dedicated pins
   input wire logic [2:0] pin_in,
   output tcg_pin_drv_s pin_drv_out,
   // Shared drive lines and acquisition
   input wire logic measure_active_in,
   input wire logic [7:0] burst_pulse_in,
   output logic [7:0] drive_line_out,
   // Key data and common change
   input tcg_key_s [15:0] key_data_in,
   input wire logic cc_compare_in,
   output logic [15:0] cc_mask_out,
   output logic common_change_flag_out,
   // Sleep control and notification
   output logic [7:0] low_power_interval_out,
   output logic sleep_out,
   output logic change_pulse_out
);
   logic [7:0] low_power_interval_ff;
   logic [7:0] drive_lines_ff;
   logic [7:0] drive_pins_ff;
   logic [7:0] pin_direction_ff;
   logic [7:0] shared_line_pwm_enable_ff;
   logic [7:0] dedicated_pin_pwm_enable_ff;
   logic [7:0] pwm_duty_level_ff;
   logic [7:0] input_wake_enable_ff;
   logic [15:0] cc_mask_ff;
   logic [2:0] pin_meta_ff;
   logic [2:0] pin_sync_ff;
   logic [2:0] pin_level_ff;
   logic [18:0] sample_cnt_ff;
   logic sample_tick;
   logic [7:0] pwm_cnt_ff;
   logic pwm_wave_ff;
   logic [7:0] drive_line_ff;
   tcg_pin_drv_s pin_drv_ff;
   logic cc_flag_ff;
   logic change_ff;
   logic sleep_ff;
   logic scl_meta_ff;
   logic scl_sync_ff;
   logic scl_prev_ff;
   logic sda_meta_ff;
   logic sda_sync_ff;
   logic sda_prev_ff;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   tcg_bus_e state_ff;
   logic [3:0] bit_cnt_ff;
   logic [7:0] shift_ff;
   logic [7:0] ptr_ff;
   logic read_dir_ff;
   logic nack_ff;
   logic sda_oe_ff;
   logic wr_stb;
   logic [7:0] rd_data;
   logic [7:0] key_off;
   logic [2:0] pin_drive;
   logic [2:0] pin_pwm;
   logic [2:0] changed;

   // Pin and bus synchronisers
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_meta_ff <= 3'h0;
         pin_sync_ff <= 3'h0;
         scl_meta_ff <= 1'b1;
         scl_sync_ff <= 1'b1;
         scl_prev_ff <= 1'b1;
         sda_meta_ff <= 1'b1;
         sda_sync_ff <= 1'b1;
         sda_prev_ff <= 1'b1;
      end else begin
         pin_meta_ff <= pin_in;
         pin_sync_ff <= pin_meta_ff;
         scl_meta_ff <= scl_in;
         scl_sync_ff <= scl_meta_ff;
         scl_prev_ff <= scl_sync_ff;
         sda_meta_ff <= sda_in;
         sda_sync_ff <= sda_meta_ff;
         sda_prev_ff <= sda_sync_ff;
      end
   end

   assign scl_rise = scl_sync_ff & ~scl_prev_ff;
   assign scl_fall = ~scl_sync_ff & scl_prev_ff;
   assign bus_start = scl_sync_ff & scl_prev_ff & ~sda_sync_ff & sda_prev_ff;
   assign bus_stop = scl_sync_ff & scl_prev_ff & sda_sync_ff & ~sda_prev_ff;

   // Byte-wide slave with auto-incrementing pointer for block accesses
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_ff <= BUS_IDLE;
         bit_cnt_ff <= 4'h0;
         shift_ff <= 8'h00;
         ptr_ff <= 8'h00;
         read_dir_ff <= 1'b0;
         nack_ff <= 1'b0;
      end else if (bus_stop) begin
         state_ff <= BUS_IDLE;
      end else if (bus_start) begin
         state_ff <= BUS_DEV;
         bit_cnt_ff <= 4'h0;
      end else if (scl_rise) begin
         case (state_ff)
            BUS_DEV, BUS_PTR, BUS_WR: begin
               shift_ff <= {shift_ff[6:0], sda_sync_ff};
               bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end
            BUS_RD: bit_cnt_ff <= bit_cnt_ff + 4'h1;
            BUS_RD_ACK: nack_ff <= sda_sync_ff;
            default: ;
         endcase
      end else if (scl_fall) begin
         case (state_ff)
            BUS_DEV: begin
               if (bit_cnt_ff == BYTE_BITS) begin
                  bit_cnt_ff <= 4'h0;
                  read_dir_ff <= shift_ff[0];
                  state_ff <= (shift_ff[7:1] == DEV_ADDR) ?
                     BUS_DEV_ACK : BUS_IDLE;
               end
            end
            BUS_DEV_ACK: begin
               if (read_dir_ff) begin
                  shift_ff <= rd_data;
                  state_ff <= BUS_RD;
               end else begin
                  state_ff <= BUS_PTR;
               end
            end
            BUS_PTR: begin
               if (bit_cnt_ff == BYTE_BITS) begin
                  bit_cnt_ff <= 4'h0;
                  ptr_ff <= shift_ff;
                  state_ff <= BUS_PTR_ACK;
               end
            end
            BUS_WR: begin
               if (bit_cnt_ff == BYTE_BITS) begin
                  bit_cnt_ff <= 4'h0;
                  ptr_ff <= ptr_ff + 8'h01;
                  state_ff <= BUS_WR_ACK;
               end
            end
            BUS_PTR_ACK, BUS_WR_ACK: state_ff <= BUS_WR;
            BUS_RD: begin
               if (bit_cnt_ff == BYTE_BITS) begin
                  bit_cnt_ff <= 4'h0;
                  ptr_ff <= ptr_ff + 8'h01;
                  state_ff <= BUS_RD_ACK;
               end else begin
                  shift_ff <= {shift_ff[6:0], 1'b0};
               end
            end
            BUS_RD_ACK: begin
               if (nack_ff) begin
                  state_ff <= BUS_IDLE;
               end else begin
                  shift_ff <= rd_data;
                  state_ff <= BUS_RD;
               end
            end
            default: state_ff <= BUS_IDLE;
         endcase
      end
   end

   // Open drain: only ever pulls low, for acknowledge bits and for read bits that are 0
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sda_oe_ff <= 1'b0;
      end else begin
         sda_oe_ff <= (state_ff == BUS_DEV_ACK) | (state_ff == BUS_PTR_ACK) |
            (state_ff == BUS_WR_ACK) | ((state_ff == BUS_RD) & ~shift_ff[7]);
      end
   end

   assign wr_stb = scl_fall & (state_ff == BUS_WR) & (bit_cnt_ff == BYTE_BITS)
      & ~bus_stop & ~bus_start;

   // Read mux; key area is two bytes per key, low byte first
   always_comb begin
      rd_data = 8'h00;
      key_off = 8'h00;
      case (ptr_ff)
         ADDR_LOW_POWER: rd_data = low_power_interval_ff;
         ADDR_DRIVE_LINES: rd_data = drive_lines_ff;
         ADDR_DRIVE_PINS: rd_data = drive_pins_ff;
         ADDR_PIN_LEVEL: rd_data = {3'h0, pin_level_ff, 2'h0};
         ADDR_PIN_DIR: rd_data = pin_direction_ff;
         ADDR_LINE_PWM: rd_data = shared_line_pwm_enable_ff;
         ADDR_PIN_PWM: rd_data = dedicated_pin_pwm_enable_ff;
         ADDR_PWM_LEVEL: rd_data = pwm_duty_level_ff;
         ADDR_WAKE: rd_data = input_wake_enable_ff;
         ADDR_CC_MASK_LO: rd_data = cc_mask_ff[7:0];
         ADDR_CC_MASK_HI: rd_data = cc_mask_ff[15:8];
         default: begin
            if (ptr_ff >= ADDR_SIGNAL_FIRST && ptr_ff <= ADDR_SIGNAL_LAST) begin
               key_off = ptr_ff - ADDR_SIGNAL_FIRST;
               rd_data = key_off[0] ?
                  key_data_in[key_off[4:1]].signal[15:8] :
                  key_data_in[key_off[4:1]].signal[7:0];
            end else if (ptr_ff >= ADDR_REF_FIRST &&
                         ptr_ff <= ADDR_REF_LAST) begin
               key_off = ptr_ff - ADDR_REF_FIRST;
               rd_data = key_off[0] ?
                  key_data_in[key_off[4:1]].reference[15:8] :
                  key_data_in[key_off[4:1]].reference[7:0];
            end
         end
      endcase
   end

   // Setup registers; writes to the key area fall through untouched
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         low_power_interval_ff <= RST_LOW_POWER;
         drive_lines_ff <= RST_ZERO;
         drive_pins_ff <= RST_ZERO;
         pin_direction_ff <= RST_ZERO;
         shared_line_pwm_enable_ff <= RST_ZERO;
         dedicated_pin_pwm_enable_ff <= RST_ZERO;
         pwm_duty_level_ff <= RST_ZERO;
         input_wake_enable_ff <= RST_ZERO;
         cc_mask_ff <= {RST_ZERO, RST_ZERO};
         sleep_ff <= 1'b0;
      end else if (wr_stb) begin
         case (ptr_ff)
            // Sleep decoded at the write so the output leaves a flop
            ADDR_LOW_POWER: begin
               low_power_interval_ff <= shift_ff;
               sleep_ff <= (shift_ff == 8'h00);
            end
            ADDR_DRIVE_LINES: drive_lines_ff <= shift_ff;
            ADDR_DRIVE_PINS: drive_pins_ff <= shift_ff & PIN_BITS;
            ADDR_PIN_DIR: pin_direction_ff <= shift_ff & PIN_BITS;
            ADDR_LINE_PWM: shared_line_pwm_enable_ff <= shift_ff;
            ADDR_PIN_PWM: dedicated_pin_pwm_enable_ff <= shift_ff & PIN_BITS;
            ADDR_PWM_LEVEL: pwm_duty_level_ff <= shift_ff;
            ADDR_WAKE: input_wake_enable_ff <= shift_ff & PIN_BITS;
            ADDR_CC_MASK_LO: cc_mask_ff[7:0] <= shift_ff;
            ADDR_CC_MASK_HI: cc_mask_ff[15:8] <= shift_ff;
            default: ;
         endcase
      end
   end

   // Input sampling runs in sleep too, so wake needs no extra path
   assign sample_tick = (sample_cnt_ff == 19'(SAMPLE_CYCLES - 1));
   assign changed = (pin_sync_ff ^ pin_level_ff) &
      ~pin_direction_ff[PIN_LSB +: 3] & input_wake_enable_ff[PIN_LSB +: 3];

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sample_cnt_ff <= 19'h00000;
         pin_level_ff <= 3'h0;
         change_ff <= 1'b0;
      end else begin
         sample_cnt_ff <= sample_tick ? 19'h00000 : sample_cnt_ff + 19'h00001;
         if (sample_tick) begin
            pin_level_ff <= pin_sync_ff;
         end
         change_ff <= sample_tick & sleep_ff & (|changed);
      end
   end

   // PWM counter free-runs; the compare result is held during bursts
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pwm_cnt_ff <= 8'h00;
         pwm_wave_ff <= 1'b1;
      end else begin
         pwm_cnt_ff <= pwm_cnt_ff + 8'h01;
         if (!measure_active_in) begin
            if (pwm_duty_level_ff <= DUTY_FULL_ON_MAX) begin
               pwm_wave_ff <= 1'b1;
            end else if (pwm_duty_level_ff >= DUTY_FULL_OFF_MIN) begin
               pwm_wave_ff <= 1'b0;
            end else begin
               pwm_wave_ff <= pwm_cnt_ff >= pwm_duty_level_ff;
            end
         end
      end
   end

   assign pin_pwm = dedicated_pin_pwm_enable_ff[PIN_LSB +: 3] &
      pin_direction_ff[PIN_LSB +: 3];
   assign pin_drive = (pin_pwm & {3{pwm_wave_ff}}) |
      (~pin_pwm & drive_pins_ff[PIN_LSB +: 3]);

   // Pin drivers
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         drive_line_ff <= 8'h00;
         pin_drv_ff <= '0;
      end else begin
         pin_drv_ff.enable <= pin_direction_ff[PIN_LSB +: 3];
         pin_drv_ff.level <= pin_drive;
         if (measure_active_in) begin
            drive_line_ff <= burst_pulse_in;
         end else begin
            drive_line_ff <= (shared_line_pwm_enable_ff & {8{pwm_wave_ff}}) |
               (~shared_line_pwm_enable_ff & drive_lines_ff);
         end
      end
   end

   // Common change flag
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cc_flag_ff <= 1'b1;
      end else begin
         cc_flag_ff <= (cc_mask_ff == 16'h0000) | cc_compare_in;
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe_out = sda_oe_ff;
   assign pin_drv_out = pin_drv_ff;
   assign drive_line_out = drive_line_ff;
   assign cc_mask_out = cc_mask_ff;
   assign common_change_flag_out = cc_flag_ff;
   assign low_power_interval_out = low_power_interval_ff;
   assign sleep_out = sleep_ff;
   assign change_pulse_out = change_ff;
endmodule

// [verif/tcg_gpio_pwm_wake_checker.sv]
`timescale 1ns/10ps
module tcg_gpio_pwm_wake_checker
   import tcg_pkg::*;
#(
   parameter int unsigned SAMPLE_CYCLES = 64
) (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // Watched ports
   input tcg_pin_drv_s pin_drv_out,
   input wire logic measure_active_in,
   input wire logic [7:0] burst_pulse_in,
   input wire logic [7:0] drive_line_out,
   input wire logic cc_compare_in,
   input wire logic [15:0] cc_mask_out,
   input wire logic common_change_flag_out,
   input wire logic [7:0] low_power_interval_out,
   input wire logic sleep_out,
   input wire logic change_pulse_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   // Gap between pulses; ticks restart with reset, so gaps are whole ticks
   int unsigned gap_ff;
   logic seen_ff;
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         gap_ff <= 32'h0;
         seen_ff <= 1'b0;
      end else begin
         gap_ff <= change_pulse_out ? 32'h1 : gap_ff + 32'h1;
         seen_ff <= seen_ff | change_pulse_out;
      end
   end
   burst_pass_a: assert property (
      $past(measure_active_in) |-> drive_line_out == $past(burst_pulse_in))
      else $error("burst not passed");
   pwm_freeze_a: assert property (
      measure_active_in && $past(measure_active_in)
      && $past(measure_active_in, 2) |-> $stable(pin_drv_out.level))
      else $error("pwm moved in burst");
   cc_empty_a: assert property (
      cc_mask_out == 16'h0000 |=> common_change_flag_out)
      else $error("empty mask flag");
   cc_compare_a: assert property (
      cc_mask_out != 16'h0000 |=>
      common_change_flag_out == $past(cc_compare_in))
      else $error("flag vs compare");
   sleep_map_a: assert property (
      sleep_out == (low_power_interval_out == 8'h00))
      else $error("sleep decode");
   wake_sleep_a: assert property (
      change_pulse_out |-> $past(sleep_out)) else $error("pulse awake");
   pulse_width_a: assert property (
      change_pulse_out |=> !change_pulse_out) else $error("pulse wide");
   sample_tick_a: assert property (
      change_pulse_out && seen_ff |-> gap_ff % SAMPLE_CYCLES == 0)
      else $error("pulse off tick");
endmodule

bind tcg_gpio_pwm_wake tcg_gpio_pwm_wake_checker
   #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_chk (
   .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
   .pin_drv_out(pin_drv_out), .measure_active_in(measure_active_in),
   .burst_pulse_in(burst_pulse_in), .drive_line_out(drive_line_out),
   .cc_compare_in(cc_compare_in), .cc_mask_out(cc_mask_out),
   .common_change_flag_out(common_change_flag_out),
   .low_power_interval_out(low_power_interval_out),
   .sleep_out(sleep_out), .change_pulse_out(change_pulse_out));

// [verif/tcg_host_model.sv]
`timescale 1ns/10ps
module tcg_host_model (
   // Bus lines
   input wire logic clk_sys_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_pull_out
);
   initial begin
      scl_out = 1'b1;
      sda_pull_out = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys_in);
      #1;
   endtask
   // Data moves 5 clocks after SCL falls, clear of the slave's sync delay
   task automatic bit_io(input logic pull, output logic seen);
      sda_pull_out = pull;
      wt(5);
      scl_out = 1'b1;
      wt(10);
      seen = sda_in;
      scl_out = 1'b0;
      wt(5);
   endtask
   task automatic bus_start();
      sda_pull_out = 1'b0;
      wt(5);
      scl_out = 1'b1;
      wt(5);
      sda_pull_out = 1'b1;
      wt(5);
      scl_out = 1'b0;
      wt(5);
   endtask
   task automatic bus_stop();
      sda_pull_out = 1'b1;
      wt(5);
      scl_out = 1'b1;
      wt(5);
      sda_pull_out = 1'b0;
      wt(10);
   endtask
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(~b[i], s);
      bit_io(1'b0, s);
      ack = ~s;
   endtask
   task automatic recv_byte(input logic last, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(1'b0, b[i]);
      bit_io(~last, s);
   endtask
endmodule

// [verif/tcg_testbench.sv]
`timescale 1ns/10ps
module testbench
   import tcg_pkg::*;
;
   localparam int unsigned SC = 64;
   localparam logic [6:0] DEV = DEV_ADDR_DEFAULT;
   localparam logic [7:0] LVLS [7] = '{8'h00, 8'h0a, 8'h0b, 8'h80,
      8'hf9, 8'hfa, 8'hff};
   logic clk_sys_in, rst_n_in, scl, sda_pull, sda_oe, sda_line;
   logic measure_active_in, cc_compare_in, common_change_flag_out;
   logic sleep_out, change_pulse_out;
   logic [2:0] pin_in;
   logic [7:0] burst_pulse_in, drive_line_out, low_power_interval_out;
   logic [15:0] cc_mask_out;
   logic [31:0] rnd;
   tcg_key_s [15:0] key_data_in;
   tcg_pin_drv_s pin_drv_out;
   int failures, n_checks;
   assign sda_line = ~(sda_pull | sda_oe);
   tcg_gpio_pwm_wake #(.SAMPLE_CYCLES(SC), .DEV_ADDR(DEV)) DUT (
      .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .scl_in(scl),
      .sda_in(sda_line), .sda_out(), .sda_oe_out(sda_oe),
      .pin_in(pin_in), .pin_drv_out(pin_drv_out),
      .measure_active_in(measure_active_in),
      .burst_pulse_in(burst_pulse_in), .drive_line_out(drive_line_out),
      .key_data_in(key_data_in), .cc_compare_in(cc_compare_in),
      .cc_mask_out(cc_mask_out),
      .common_change_flag_out(common_change_flag_out),
      .low_power_interval_out(low_power_interval_out),
      .sleep_out(sleep_out), .change_pulse_out(change_pulse_out));
   tcg_host_model host (.clk_sys_in(clk_sys_in), .sda_in(sda_line),
      .scl_out(scl), .sda_pull_out(sda_pull));
   initial begin
      clk_sys_in = 1'b0;
      forever #25 clk_sys_in = ~clk_sys_in;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic int duty(input logic [7:0] l);
      if (l <= 8'h0a) return 256;
      if (l >= 8'hfa) return 0;
      return 256 - int'(l);
   endfunction
   task automatic test_done();
      if (failures == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic ok, input string what);
      n_checks++;
      if (ok !== 1'b1) begin
         failures++;
         $display("Error at %0t ns: %s", $time, what);
      end
   endtask
   task automatic tx(input logic [7:0] b, input logic exp);
      logic a;
      host.send_byte(b, a);
      check(a === exp, "acknowledge");
   endtask
   task automatic head(input logic [7:0] a);
      host.bus_start();
      tx({DEV, 1'b0}, 1'b1);
      tx(a, 1'b1);
   endtask
   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      head(a);
      tx(d, 1'b1);
      host.bus_stop();
   endtask
   task automatic wr16(input logic [7:0] a, input logic [15:0] d);
      head(a);
      tx(d[7:0], 1'b1);
      tx(d[15:8], 1'b1);
      host.bus_stop();
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
      logic [15:0] v;
      head(a);
      host.bus_start();
      tx({DEV, 1'b1}, 1'b1);
      host.recv_byte(1'b0, v[7:0]);
      host.recv_byte(1'b1, v[15:8]);
      host.bus_stop();
      check(v === e, "read data");
   endtask
   task automatic pulses(input int n, input int p, output int c);
      c = 0;
      for (int i = 0; i < n; i++) begin
         if (p != 0 && i % p == 0) pin_in[0] = ~pin_in[0];
         host.wt(1);
         if (change_pulse_out === 1'b1) c++;
      end
   endtask
   initial begin
      repeat (100000) @(posedge clk_sys_in);
      failures++;
      $display("Error at %0t ns: run limit", $time);
      test_done();
   end
   initial begin
      logic [7:0] lvl;
      logic [15:0] m;
      int hp, hz, hl, c, k;
      rnd = 32'hf8b2a121;
      failures = 0;
      n_checks = 0;
      rst_n_in = 1'b0;
      pin_in = 3'b000;
      measure_active_in = 1'b0;
      cc_compare_in = 1'b0;
      burst_pulse_in = 8'h00;
      for (int i = 0; i < 16; i++) begin
         rnd = lfsr(rnd);
         key_data_in[i] = rnd;
      end
      repeat (4) @(posedge clk_sys_in);
      #1;
      rst_n_in = 1'b1;
      host.wt(4);
      rd_chk(ADDR_LOW_POWER, 16'h0001);
      rd_chk(ADDR_PIN_DIR, 16'h0000);
      rd_chk(ADDR_PIN_PWM, 16'h0000);
      rd_chk(ADDR_WAKE, 16'h0000);
      rd_chk(ADDR_CC_MASK_HI, 16'h0000);
      check(pin_drv_out.enable === 3'b000, "pins at reset");
      wr16(ADDR_PIN_DIR, 16'hffff);
      rd_chk(ADDR_PIN_DIR, 16'hff1c);
      wr8(ADDR_WAKE, 8'hff);
      rd_chk(ADDR_WAKE, 16'h001c);
      wr8(ADDR_WAKE, 8'h00);
      wr8(8'h50, 8'h5a);
      rd_chk(8'h50, 16'h0000);
      host.bus_start();
      tx({DEV ^ 7'h01, 1'b0}, 1'b0);
      host.bus_stop();
      // Pin 1 drive bit is 1 but its PWM must win; pin 3 stays static
      wr16(ADDR_DRIVE_LINES, 16'h1400);
      wr8(ADDR_PIN_PWM, 8'h04);
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         lvl = (i == 7) ? rnd[7:0] : LVLS[i];
         wr8(ADDR_PWM_LEVEL, lvl);
         host.wt(4);
         hp = 0;
         hz = 0;
         hl = 0;
         repeat (256) begin
            hp += int'(pin_drv_out.level[0] === 1'b1);
            hz += int'(pin_drv_out.level[0] === 1'b0);
            hl += int'(drive_line_out[0] === 1'b1);
            host.wt(1);
         end
         check(hp == duty(lvl) && hp + hz == 256, "pin duty");
         check(hl == duty(lvl), "line duty");
         check(pin_drv_out.level[2] === 1'b1, "static pin");
      end
      // Bursts cut into the PWM; pass-through and freeze are asserted
      for (int i = 0; i < 30; i++) begin
         measure_active_in = 1'b1;
         repeat (12) begin
            rnd = lfsr(rnd);
            burst_pulse_in = rnd[7:0];
            host.wt(1);
         end
         measure_active_in = 1'b0;
         host.wt(1 + int'(rnd[3:0]));
      end
      wr16(ADDR_PIN_DIR, 16'h0018);
      wr8(ADDR_PWM_LEVEL, 8'hff);
      wr8(ADDR_DRIVE_LINES, 8'ha5);
      check(drive_line_out === 8'ha5, "static lines");
      check(pin_drv_out.enable === 3'b110, "input pin pwm");
      check(pin_drv_out.level[0] === 1'b1, "pwm on input");
      for (int i = 0; i < 3; i++) begin
         rnd = lfsr(rnd);
         k = (i == 0) ? 0 : (i == 1) ? int'(rnd[3:0]) : 15;
         key_data_in[k] = ~rnd;
         rd_chk(ADDR_SIGNAL_FIRST + 8'(2 * k), key_data_in[k].signal);
         rd_chk(ADDR_REF_FIRST + 8'(2 * k), key_data_in[k].reference);
      end
      wr16(ADDR_SIGNAL_FIRST, ~key_data_in[0].signal);
      wr16(ADDR_REF_LAST - 8'h01, ~key_data_in[15].reference);
      rd_chk(ADDR_SIGNAL_FIRST, key_data_in[0].signal);
      rd_chk(ADDR_REF_LAST - 8'h01, key_data_in[15].reference);
      rnd = lfsr(rnd);
      m = rnd[15:0] | 16'h8001;
      wr16(ADDR_CC_MASK_LO, m);
      rd_chk(ADDR_CC_MASK_LO, m);
      check(cc_mask_out === m, "mask");
      check(common_change_flag_out === 1'b0, "flag");
      repeat (20) begin
         rnd = lfsr(rnd);
         cc_compare_in = rnd[0];
         host.wt(1);
      end
      cc_compare_in = 1'b0;
      wr16(ADDR_CC_MASK_LO, 16'h0000);
      check(common_change_flag_out === 1'b1, "empty mask");
      wr8(ADDR_PIN_DIR, 8'h10);
      wr8(ADDR_WAKE, 8'h04);
      wr8(ADDR_LOW_POWER, 8'h00);
      check(sleep_out === 1'b1, "sleep");
      host.wt(2 * SC);
      pin_in = 3'b110;
      pulses(3 * SC, 0, c);
      check(c == 0, "unwatched pins");
      pin_in[0] = 1'b1;
      pulses(2 * SC, 0, c);
      check(c == 1, "wake pulse");
      rd_chk(ADDR_PIN_LEVEL, 16'h101c);
      pulses(6 * SC, SC, c);
      check(c >= 5, "repeat pulses");
      wr8(ADDR_LOW_POWER, 8'h05);
      pulses(4 * SC, SC, c);
      check(c == 0 && sleep_out === 1'b0, "awake pulse");
      // Second reset in mid-run: setups and outputs fall back to defaults
      rst_n_in = 1'b0;
      host.wt(3);
      check(drive_line_out === 8'h00, "reset lines");
      check(pin_drv_out === 6'h00, "reset pins");
      check(low_power_interval_out === 8'h01, "reset interval");
      rst_n_in = 1'b1;
      host.wt(4);
      rd_chk(ADDR_PIN_DIR, 16'h0000);
      check(common_change_flag_out === 1'b1, "reset flag");
      test_done();
   end
endmodule
